// file: rtl/twx_exec.v
// Execute stage for table write, test-skip, exclusive-OR and extensions
`include "twx_consts.vh"
module twx_exec (
	// Clock, reset, enable
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        ce,
	// Configuration
	input  wire        extended_set_enable,
	// Instruction from fetch, one word per cycle at Q1
	input  wire [15:0] instr,
	input  wire        instr_valid,
	// Data memory read data and core registers
	input  wire [7:0]  file_rdata,
	input  wire [7:0]  table_latch,
	input  wire [3:0]  bank_select_reg,
	// Phase and sequencing outputs
	output reg  [1:0]  q_phase,
	output reg         flush_fetch,
	output reg         busy,
	// Data memory access
	output reg  [11:0] file_addr,
	output reg         file_rd,
	output reg         file_wr,
	output reg  [7:0]  file_wdata,
	// Accumulator and flags
	output reg  [7:0]  acc,
	output reg         flag_n,
	output reg         flag_z,
	// Table pointer and holding register view
	output reg  [20:0] table_pointer,
	output reg  [7:0]  hold_view,
	// File select pointers, return request and extension-seen flag
	output reg  [11:0] pointer_reg_zero,
	output reg  [11:0] pointer_reg_one,
	output reg  [11:0] pointer_reg_two,
	output reg         return_req,
	output reg         ext_op_seen
);
	////////////////////////////////////////////////////////////////////////
	// Decode functions

	// Effective file address: access bank, indexed or banked
	function [11:0] eff_addr;
		input [7:0]  f;
		input        a;
		input        xen;
		input [3:0]  bank;
		input [11:0] ptr_two;
		begin
			if (a)
				eff_addr = {bank, f};
			else if (xen && f <= `TWX_ILO_MAX)
				eff_addr = ptr_two + {4'h0, f};
			else if (f < `TWX_ACC_HI)
				eff_addr = {`TWX_ACC_BANK, f};
			else
				eff_addr = {`TWX_ACC_SFR, f};
		end
	endfunction

	// Two-word instruction detector for the word after a skip
	function is_two_word;
		input [15:0] w;
		input        xen;
		begin
			is_two_word = (w[15:9] == `TWX_OP_CALL) ||
				(w[15:8] == `TWX_OP_GOTO) ||
				(w[15:8] == `TWX_OP_LFSR) ||
				(w[15:12] == `TWX_OP_MOVFF) ||
				(xen && w[15:12] == `TWX_OP_EXT &&
				 w[11:8] == `TWX_OP_MOVS);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [15:0] ir;
	reg  [7:0]  tw_data;
	reg         hold_we;
	reg  [2:0]  hold_sel;
	wire [7:0]  hold_rd;

	// Decoded fields, common to both sets
	wire [7:0] fld_f  = ir[7:0];
	wire       fld_a  = ir[8];
	wire       fld_d  = ir[9];
	wire [1:0] fld_ff = ir[7:6];
	wire [5:0] fld_k6 = ir[5:0];

	wire dec_tbl_wr    = ir[15:2] == `TWX_OP_TBL_WR_HI;
	wire dec_xor_lit   = ir[15:8] == `TWX_OP_XOR_LIT;
	wire dec_xor_file  = ir[15:10] == `TWX_OP_XOR_FILE;
	wire dec_test_skip = ir[15:9] == `TWX_OP_TEST_SKIP;
	wire dec_ext       = extended_set_enable &&
		ir[15:12] == `TWX_OP_EXT;
	wire dec_callw     = extended_set_enable && ir == `TWX_OP_CALLW;

	wire [11:0] ea = eff_addr(fld_f, fld_a, extended_set_enable,
		bank_select_reg, pointer_reg_two);
	wire [7:0] xor_res = acc ^ (dec_xor_lit ? fld_f : file_rdata);

	////////////////////////////////////////////////////////////////////////
	// Holding registers

	twx_hold_regs u_hold (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.wr_en   (hold_we),
		.wr_sel  (hold_sel),
		.wr_data (tw_data),
		.rd_sel  (table_pointer[2:0]),
		.rd_data (hold_rd)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state

	always @* begin
		next_state = state;
		case (state)
		`TWX_ST_EXEC: begin
			if (q_phase == `TWX_Q4 && instr_valid) begin
				if (dec_tbl_wr)
					next_state = `TWX_ST_TW2;
				else if (dec_test_skip && file_rdata == 8'h00)
					next_state = `TWX_ST_SKIP;
			end
		end
		`TWX_ST_TW2:
			if (q_phase == `TWX_Q4)
				next_state = `TWX_ST_EXEC;
		`TWX_ST_SKIP:
			if (q_phase == `TWX_Q4)
				next_state = is_two_word(instr, extended_set_enable) ?
					`TWX_ST_SKP2 : `TWX_ST_EXEC;
		`TWX_ST_SKP2:
			if (q_phase == `TWX_Q4)
				next_state = `TWX_ST_EXEC;
		default:
			next_state = `TWX_ST_EXEC;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Main clocked process

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state            <= `TWX_ST_EXEC;
			q_phase          <= `TWX_Q1;
			ir               <= 16'h0000;
			tw_data          <= 8'h00;
			hold_we          <= 1'b0;
			hold_sel         <= 3'h0;
			flush_fetch      <= 1'b0;
			busy             <= 1'b0;
			file_addr        <= 12'h000;
			file_rd          <= 1'b0;
			file_wr          <= 1'b0;
			file_wdata       <= 8'h00;
			acc              <= 8'h00;
			flag_n           <= 1'b0;
			flag_z           <= 1'b0;
			table_pointer    <= `TWX_PTR_RST;
			hold_view        <= 8'hff;
			pointer_reg_zero <= `TWX_FSR_RST;
			pointer_reg_one  <= `TWX_FSR_RST;
			pointer_reg_two  <= `TWX_FSR_RST;
			return_req       <= 1'b0;
			ext_op_seen      <= 1'b0;
		end else if (ce) begin
			q_phase     <= q_phase + 2'h1;
			state       <= next_state;
			hold_we     <= 1'b0;
			file_wr     <= 1'b0;
			file_rd     <= 1'b0;
			flush_fetch <= 1'b0;
			return_req  <= 1'b0;
			ext_op_seen <= 1'b0;
			hold_view   <= hold_rd;
			busy        <= next_state != `TWX_ST_EXEC;
			case (q_phase)
			// Q1: latch in execute; table write keeps its mode bits
			`TWX_Q1: begin
				if (state == `TWX_ST_EXEC)
					ir <= instr_valid ? instr : 16'h0000;
				else if (state != `TWX_ST_TW2)
					ir <= 16'h0000;
			end
			// Q2: present file address, read the latch
			`TWX_Q2: begin
				if (state == `TWX_ST_EXEC &&
				    (dec_xor_file || dec_test_skip)) begin
					file_addr <= ea;
					file_rd   <= 1'b1;
				end
				if (state == `TWX_ST_TW2)
					tw_data <= table_latch;
			end
			// Q3: processing is combinational
			`TWX_Q3: begin
			end
			// Q4: write results and move pointers
			default: begin
				if (state == `TWX_ST_EXEC && dec_xor_lit) begin
					acc    <= xor_res;
					flag_n <= xor_res[7];
					flag_z <= xor_res == 8'h00;
				end
				if (state == `TWX_ST_EXEC && dec_xor_file) begin
					flag_n <= xor_res[7];
					flag_z <= xor_res == 8'h00;
					if (fld_d) begin
						file_wdata <= xor_res;
						file_wr    <= 1'b1;
					end else
						acc <= xor_res;
				end
				if (state == `TWX_ST_EXEC && dec_test_skip &&
				    file_rdata == 8'h00)
					flush_fetch <= 1'b1;
				if (state == `TWX_ST_TW2) begin
					hold_we <= 1'b1;
					case (ir[1:0])
					`TWX_TW_POST: begin
						hold_sel <= table_pointer[2:0];
						table_pointer <= table_pointer +
							`TWX_PTR_ONE;
					end
					`TWX_TW_DEC: begin
						hold_sel <= table_pointer[2:0];
						table_pointer <= table_pointer -
							`TWX_PTR_ONE;
					end
					`TWX_TW_PRE: begin
						hold_sel <= table_pointer[2:0] + 3'h1;
						table_pointer <= table_pointer +
							`TWX_PTR_ONE;
					end
					default:
						hold_sel <= table_pointer[2:0];
					endcase
				end
				if (state == `TWX_ST_EXEC && dec_ext) begin
					ext_op_seen <= 1'b1;
					if (ir[11:8] == `TWX_OP_PTR_ADD ||
					    ir[11:8] == `TWX_OP_PTR_SUB) begin
						if (fld_ff == `TWX_FSR_ULNK) begin
							pointer_reg_two <= ir[8] ?
								pointer_reg_two - {6'h00, fld_k6} :
								pointer_reg_two + {6'h00, fld_k6};
							return_req <= 1'b1;
						end else if (fld_ff == `TWX_FSR_TWO)
							pointer_reg_two <= ir[8] ?
								pointer_reg_two - {6'h00, fld_k6} :
								pointer_reg_two + {6'h00, fld_k6};
						else if (fld_ff[0])
							pointer_reg_one <= ir[8] ?
								pointer_reg_one - {6'h00, fld_k6} :
								pointer_reg_one + {6'h00, fld_k6};
						else
							pointer_reg_zero <= ir[8] ?
								pointer_reg_zero - {6'h00, fld_k6} :
								pointer_reg_zero + {6'h00, fld_k6};
					end else if (ir[11:8] == `TWX_OP_PUSHL) begin
						file_addr  <= pointer_reg_two;
						file_wdata <= fld_f;
						file_wr    <= 1'b1;
						pointer_reg_two <= pointer_reg_two - 12'h001;
					end
				end
				if (state == `TWX_ST_EXEC && dec_callw)
					ext_op_seen <= 1'b1;
			end
			endcase
		end
	end
endmodule

// file: rtl/twx_hold_regs.v
// Eight-byte program memory holding register bank
`include "twx_consts.vh"
module twx_hold_regs (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rst,
	input  wire       ce,
	// Write port
	input  wire       wr_en,
	input  wire [2:0] wr_sel,
	input  wire [7:0] wr_data,
	// Read port
	input  wire [2:0] rd_sel,
	output reg  [7:0] rd_data
);
	reg [7:0] mem [0:7];
	integer   i;

	// Only the selected entry is touched on a write
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 8; i = i + 1)
				mem[i] <= 8'hff;
			rd_data <= 8'hff;
		end else if (ce) begin
			if (wr_en)
				mem[wr_sel] <= wr_data;
			rd_data <= mem[rd_sel];
		end
	end
endmodule

// file: shared/twx_consts.vh
// Constants for the table-write, test-skip and exclusive-OR execute block
`ifndef TWX_CONSTS_VH
`define TWX_CONSTS_VH
// Q phases of an instruction cycle
`define TWX_Q1 2'h0
`define TWX_Q2 2'h1
`define TWX_Q3 2'h2
`define TWX_Q4 2'h3
// Opcode patterns
`define TWX_OP_TBL_WR_HI 14'h0003
`define TWX_OP_XOR_LIT   8'h0a
`define TWX_OP_XOR_FILE  6'h06
`define TWX_OP_TEST_SKIP 7'h33
`define TWX_OP_EXT      4'he
`define TWX_OP_PTR_ADD  4'h8
`define TWX_OP_PTR_SUB  4'h9
`define TWX_OP_PUSHL    4'ha
`define TWX_OP_MOVS     4'hb
`define TWX_OP_CALLW    16'h0014
`define TWX_OP_2ND      4'hf
`define TWX_OP_CALL     7'h76
`define TWX_OP_GOTO     8'hef
`define TWX_OP_LFSR     8'hee
`define TWX_OP_MOVFF    4'hc
// Table write pointer modes
`define TWX_TW_NONE 2'h0
`define TWX_TW_POST 2'h1
`define TWX_TW_DEC  2'h2
`define TWX_TW_PRE  2'h3
// Field limits and widths
`define TWX_ILO_MAX  8'h5f
`define TWX_PTR_ONE  21'h000001
`define TWX_PTR_RST  21'h000000
`define TWX_FSR_RST  12'h000
`define TWX_ACC_BANK 4'h0
`define TWX_ACC_HI   8'h60
`define TWX_ACC_SFR  4'hf
`define TWX_FSR_TWO  2'h2
`define TWX_FSR_ULNK 2'h3
// Sequencer states
`define TWX_ST_EXEC 2'h0
`define TWX_ST_TW2  2'h1
`define TWX_ST_SKIP 2'h2
`define TWX_ST_SKP2 2'h3
`endif

// file: sim/tb_top.sv
// Self-checking bench for the execute block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst, ce, extended_set_enable, instr_valid;
	logic        flush_fetch, busy, file_rd, file_wr, flag_n, flag_z;
	logic        return_req, ext_op_seen;
	logic [1:0]  q_phase;
	logic [15:0] instr;
	logic [3:0]  bank_select_reg;
	logic [7:0]  file_rdata, table_latch, file_wdata, acc, hold_view;
	logic [11:0] file_addr, pointer_reg_zero, pointer_reg_one, pointer_reg_two;
	logic [20:0] table_pointer;
	int          errors, checked, nb, nf, rr, ne, nr;
	twx_exec dut_u (.clk_sys, .rst, .ce, .extended_set_enable, .instr,
		.instr_valid, .file_rdata, .table_latch, .bank_select_reg, .q_phase,
		.flush_fetch, .busy, .file_addr, .file_rd, .file_wr, .file_wdata, .acc,
		.flag_n, .flag_z, .table_pointer, .hold_view, .pointer_reg_zero,
		.pointer_reg_one, .pointer_reg_two, .return_req, .ext_op_seen);
	twx_mem_model mem_u (.clk_sys, .file_addr, .file_rd, .file_wr,
		.file_wdata, .file_rdata);
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [20:0] e, input logic [20:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task results;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Issue w at Q1, then nxt as the following word; count pulses
	task op(input logic [15:0] w, input logic [15:0] nxt);
		do @(negedge clk_sys); while (q_phase !== 2'h3);
		@(posedge clk_sys) instr <= w;
		@(posedge clk_sys) instr <= nxt;
		nb = 0;
		nf = 0;
		rr = 0;
		ne = 0;
		nr = 0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			if (i == 6)
				instr <= 16'h0000;
			#1;
			nb += busy === 1'b1;
			nf += flush_fetch === 1'b1;
			rr += return_req === 1'b1;
			ne += ext_op_seen === 1'b1;
			nr += file_rd === 1'b1;
		end
	endtask
	// One table write in mode m with latch l
	task tw(input logic [1:0] m, input logic [7:0] l, input logic [20:0] p,
		input logic [7:0] h);
		@(posedge clk_sys) table_latch <= l;
		op({14'h0003, m}, 16'h0000);
		chk("pointer", p, table_pointer);
		chk("holding", h, hold_view);
		chk("busy", 4, nb);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Watchdog
	initial begin
		#100us;
		errors++;
		results;
	end
	// Test sequence
	initial begin
		{rst, ce, instr_valid} = 3'b111;
		{extended_set_enable, instr, table_latch} = '0;
		bank_select_reg = 4'h3;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		mem_u.mem[12'h020] = 8'haf;
		mem_u.mem[12'h320] = 8'h3c;
		mem_u.mem[12'hf70] = 8'h0f;
		mem_u.mem[12'h033] = 8'h5a;
		op(16'h0ab5, 16'h0);
		chk("acc", 8'hb5, acc);
		chk("flags", 2'b10, {flag_n, flag_z});
		chk("reads", 0, nr);
		op(16'h0ab5, 16'h0);
		chk("flags", 2'b01, {flag_n, flag_z});
		op(16'h0ab5, 16'h0);
		op(16'h1a20, 16'h0);
		chk("file", 8'haf ^ 8'hb5, mem_u.mem[12'h020]);
		chk("acc", 8'hb5, acc);
		chk("flags", 2'b00, {flag_n, flag_z});
		chk("reads", 1, nr);
		op(16'h1920, 16'h0);
		chk("acc", 8'hb5 ^ 8'h3c, acc);
		op(16'h1870, 16'h0);
		chk("acc", 8'h89 ^ 8'h0f, acc);
		$display("xor test done");
		op(16'he8a3, 16'h0);
		chk("pointer two", 12'h000, pointer_reg_two);
		chk("ext seen", 0, ne);
		@(posedge clk_sys) extended_set_enable <= 1'b1;
		op(16'he8a3, 16'h0);
		chk("pointer two", 12'h023, pointer_reg_two);
		chk("ext seen", 1, ne);
		op(16'h1810, 16'h0);
		chk("acc", 8'h86 ^ 8'h5a, acc);
		op(16'he8c5, 16'h0);
		chk("pointer two", 12'h028, pointer_reg_two);
		chk("return", 1, rr);
		op(16'heaa7, 16'h0);
		chk("pushed", 8'ha7, mem_u.mem[12'h028]);
		chk("pointer two", 12'h027, pointer_reg_two);
		op(16'he805, 16'h0);
		chk("pointer zero", 12'h005, pointer_reg_zero);
		chk("return", 0, rr);
		op(16'he945, 16'h0);
		chk("pointer one", 12'hffb, pointer_reg_one);
		op(16'h0014, 16'h0);
		chk("ext seen", 1, ne);
		@(posedge clk_sys) extended_set_enable <= 1'b0;
		$display("extended test done");
		op(16'h6620, 16'h0);
		chk("busy", 0, nb);
		op(16'h6650, 16'h0aff);
		chk("busy", 4, nb);
		chk("flush", 1, nf);
		chk("acc", 8'hdc, acc);
		op(16'h6650, 16'hef00);
		chk("busy", 8, nb);
		chk("flags", 2'b10, {flag_n, flag_z});
		$display("skip test done");
		tw(2'h1, 8'h55, 21'h000001, 8'hff);
		tw(2'h2, 8'h66, 21'h000000, 8'h55);
		tw(2'h2, 8'h22, 21'h1fffff, 8'hff);
		tw(2'h3, 8'h34, 21'h000000, 8'h34);
		tw(2'h0, 8'h77, 21'h000000, 8'h77);
		chk("flags", 2'b10, {flag_n, flag_z});
		$display("table write test done");
		results;
	end
endmodule

// file: sim/twx_mem_model.sv
// Data memory model facing the execute block
module twx_mem_model (
	// Clock
	input  logic        clk_sys,
	// Access port
	input  logic [11:0] file_addr,
	input  logic        file_rd,
	input  logic        file_wr,
	input  logic [7:0]  file_wdata,
	output logic [7:0]  file_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:4095];
	logic       hold;
	// Cleared array, idle read bus
	initial begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'h00;
		file_rdata = 8'h00;
		hold = 1'b0;
	end
	// Read data stands two clocks, then toggles like a stale bus
	always @(posedge clk_sys) begin
		if (file_wr)
			mem[file_addr] <= file_wdata;
		if (file_rd)
			file_rdata <= mem[file_addr];
		else if (!hold)
			file_rdata <= ~file_rdata;
		hold <= file_rd;
	end
endmodule

// file: sim/twx_monitor.sv
// Port checks for the execute block
module twx_monitor (
	// Inputs
	input logic        clk_sys,
	input logic        rst,
	input logic        ce,
	input logic        extended_set_enable,
	input logic [15:0] instr,
	input logic        instr_valid,
	input logic [7:0]  file_rdata,
	input logic [3:0]  bank_select_reg,
	// Outputs
	input logic [1:0]  q_phase,
	input logic        busy,
	input logic [11:0] file_addr,
	input logic        file_wr,
	input logic [7:0]  file_wdata,
	input logic [7:0]  acc,
	input logic        flag_n,
	input logic        flag_z,
	input logic [20:0] table_pointer,
	input logic [11:0] pointer_reg_two
);
	timeunit 1ns;
	timeprecision 1ps;
	// Decode helpers; tk marks a taken instruction
	wire        tk = ce && q_phase == 2'h0 && !busy && instr_valid;
	wire        fop = instr[15:10] == 6'h06 || instr[15:9] == 7'h33;
	wire        twr = instr[15:2] == 14'h0003;
	wire [7:0]  f = instr[7:0];
	wire [20:0] stp = instr[1:0] == 2'h2 ? 21'h1fffff : {20'h0, instr[0]};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_xor_lit;
		tk && instr[15:8] == 8'h0a |-> ##4 acc == ($past(acc, 4) ^ $past(f, 4))
			&& flag_n == acc[7] && flag_z == (acc == 8'h00);
	endproperty
	a_xor_lit: assert property (p_xor_lit)
		else $error("literal xor wrong");
	property p_xacc;
		tk && instr[15:9] == 7'h0c |-> ##4 !file_wr
			&& acc == ($past(acc, 4) ^ $past(file_rdata));
	endproperty
	a_xacc: assert property (p_xacc)
		else $error("xor into acc wrong");
	property p_xfile;
		tk && instr[15:9] == 7'h0d |-> ##4 file_wr && acc == $past(acc, 4)
			&& file_wdata == ($past(acc, 4) ^ $past(file_rdata));
	endproperty
	a_xfile: assert property (p_xfile)
		else $error("xor into file wrong");
	property p_banked;
		tk && fop && instr[8]
			|-> ##2 file_addr == {$past(bank_select_reg, 2), $past(f, 2)};
	endproperty
	a_banked: assert property (p_banked)
		else $error("banked address wrong");
	property p_abank;
		tk && fop && !instr[8] && !(extended_set_enable && f <= 8'h5f)
			|-> ##2 file_addr == {(($past(f, 2) > 8'h5f) ? 4'hf : 4'h0),
			$past(f, 2)};
	endproperty
	a_abank: assert property (p_abank)
		else $error("access bank address wrong");
	property p_index;
		tk && fop && !instr[8] && extended_set_enable && f <= 8'h5f
			|-> ##2 file_addr == $past(pointer_reg_two, 2) + $past(f, 2);
	endproperty
	a_index: assert property (p_index)
		else $error("indexed address wrong");
	property p_keep;
		tk && (twr || instr[15:9] == 7'h33)
			|-> ##1 ($stable(flag_n) && $stable(flag_z))[*7];
	endproperty
	a_keep: assert property (p_keep)
		else $error("flags changed");
	property p_tptr;
		tk && twr
			|-> ##8 table_pointer == $past(table_pointer, 8) + $past(stp, 8);
	endproperty
	a_tptr: assert property (p_tptr)
		else $error("table pointer wrong");
	// Main scenarios reached
	c_skip: cover property (tk && instr[15:9] == 7'h33);
	c_tw: cover property (tk && twr);
	c_busy: cover property (busy);
endmodule
bind twx_exec twx_monitor mon_u (.clk_sys, .rst, .ce, .extended_set_enable,
	.instr, .instr_valid, .file_rdata, .bank_select_reg, .q_phase, .busy,
	.file_addr, .file_wr, .file_wdata, .acc, .flag_n, .flag_z, .table_pointer,
	.pointer_reg_two);
